/* File: inc/lssr_pkg.sv */
// Constants and carrier types for the link and sensor status register bank.
// Assumes a Wishbone slave with 32-bit data, one 8-bit register per aligned word.
package lssr_pkg;

    // ----------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------
    localparam logic [7:0] IDX_BC_CONTROL = 8'h49;
    localparam logic [7:0] IDX_PIN_LEVELS = 8'h53;
    localparam logic [7:0] IDX_SELFTEST_ERRS = 8'h54;
    localparam logic [7:0] IDX_CRC_ERRS_LOW = 8'h55;
    localparam logic [7:0] IDX_CRC_ERRS_HIGH = 8'h56;
    localparam logic [7:0] IDX_ALARM_FLAGS = 8'h57;
    localparam logic [7:0] IDX_PIN0_CAPTURE = 8'h58;
    localparam logic [7:0] IDX_PIN1_CAPTURE = 8'h59;
    localparam logic [7:0] IDX_TEMP_CAPTURE = 8'h5A;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BC_SELFTEST_WIPE_BIT = 5;
    localparam int BC_SPARE_BIT = 4;
    localparam int BC_CRC_WIPE_BIT = 3;
    localparam int BC_TIMER_MSB = 2;
    localparam int FLAG_OVERTEMP_BIT = 5;
    localparam int FLAG_UNDERTEMP_BIT = 4;
    localparam int FLAG_PIN1_OVER_BIT = 3;
    localparam int FLAG_PIN1_UNDER_BIT = 2;
    localparam int FLAG_PIN0_OVER_BIT = 1;
    localparam int FLAG_PIN0_UNDER_BIT = 0;
    localparam int CAP_PEAK_LSB = 4;
    localparam int CAP_SPARE_HI_BIT = 7;
    localparam int CAP_SPARE_LO_BIT = 3;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int READING_W = 3;
    localparam int PIN_COUNT = 4;
    localparam int SELFTEST_CNT_W = 8;
    localparam int CRC_CNT_W = 16;
    localparam logic [2:0] PEAK_RESET = 3'h0;
    localparam logic [2:0] TROUGH_RESET = 3'h7;
    localparam logic [2:0] TIMER_RESET = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // One monitored quantity: present reading and its programmed limits
    typedef struct packed {
        logic [READING_W-1:0] reading;
        logic [READING_W-1:0] upper_limit;
        logic [READING_W-1:0] lower_limit;
    } lssr_sense_t;

    // What a monitor reports
    typedef struct packed {
        logic over_flag;
        logic under_flag;
        logic [READING_W-1:0] peak;
        logic [READING_W-1:0] trough;
    } lssr_alarm_t;

endpackage

/* File: core/lssr_err_counter.sv */
// Saturating event counter with a synchronous wipe.
// Assumes inc_i is a one-cycle qualified event in the clk_i domain.
module lssr_err_counter #(
    parameter int WIDTH = 8
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic inc_i,
    input wire logic wipe_i,
    // Count
    output logic [WIDTH-1:0] count_o
);

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    // An event in the wipe cycle is kept, so the count restarts at one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (ce_i) begin
            if (wipe_i) begin
                count_o <= inc_i ? WIDTH'(1) : '0;
            end else if (inc_i && count_o != '1) begin
                count_o <= count_o + WIDTH'(1);
            end
        end
    end

endmodule

/* File: core/lssr_monitor.sv */
// Alarm flags and alarm-time extremes for one monitored quantity.
// Assumes reading and limits are synchronous and steady for a cycle at least.
module lssr_monitor (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Sensing and read-clears
    input wire lssr_pkg::lssr_sense_t sense_i,
    input wire logic flag_clr_i,
    input wire logic cap_clr_i,
    // Result
    output lssr_pkg::lssr_alarm_t alarm_o
);

    logic above;
    logic below;
    logic over_r;
    logic under_r;
    logic [lssr_pkg::READING_W-1:0] peak_r;
    logic [lssr_pkg::READING_W-1:0] trough_r;

    assign above = sense_i.reading > sense_i.upper_limit;
    assign below = sense_i.reading < sense_i.lower_limit;
    assign alarm_o = {over_r, under_r, peak_r, trough_r};

    // ----------------------------------------
    // Sticky flags, set wins over read-clear
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            over_r <= 1'b0;
            under_r <= 1'b0;
        end else if (ce_i) begin
            over_r <= (over_r & ~flag_clr_i) | above;
            under_r <= (under_r & ~flag_clr_i) | below;
        end
    end

    // ----------------------------------------
    // Extremes seen while in alarm
    // ----------------------------------------
    // A read restarts from the idle value but keeps the reading taken that cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            peak_r <= lssr_pkg::PEAK_RESET;
            trough_r <= lssr_pkg::TROUGH_RESET;
        end else if (ce_i) begin
            if (cap_clr_i) begin
                peak_r <= above ? sense_i.reading : lssr_pkg::PEAK_RESET;
                trough_r <= below ? sense_i.reading : lssr_pkg::TROUGH_RESET;
            end else begin
                if (above && sense_i.reading > peak_r) begin
                    peak_r <= sense_i.reading;
                end
                if (below && sense_i.reading < trough_r) begin
                    trough_r <= sense_i.reading;
                end
            end
        end
    end

endmodule

/* File: core/lssr_top.sv */
// Link and sensor status register bank, top level.
// Assumes a classic Wishbone master on clk_i and synchronous status inputs.
//
// Added by the designer: the Wishbone register port.

// What this block does
// - Pin status register shows four pin levels in bits 3:0, bits 7:4 zero.
// - Eight-bit count of return-link CRC errors while self test runs, reset zero.
// - Sixteen-bit CRC error count, reset zero, low byte then high byte register.
// - Alarm bit 5 sets when temperature exceeds upper limit; clears on read.
// - Alarm bit 4 sets when temperature falls below lower limit; clears on read.
// - Alarm bit 3 sets when pin 1 voltage exceeds upper limit; clears on read.
// - Alarm bit 2 sets when pin 1 voltage below lower limit; clears on read.
// - Alarm bit 1 sets when pin 0 voltage exceeds upper limit; clears on read.
// - Alarm bit 0 sets when pin 0 voltage below lower limit; clears on read.
// - Pin 0 capture bits 6:4 hold highest reading above limit; 0 idle, read clears.
// - Pin 0 capture bits 2:0 hold lowest reading below limit; 7 idle, read clears.
// - Pin 1 capture bits 6:4 hold highest reading above limit; 0 idle, read clears.
// - Pin 1 capture bits 2:0 hold lowest reading below limit; 7 idle, read clears.
// - Temperature capture bits 6:4 hold maximum above limit; 0 idle, read clears.
// - Temperature capture bits 2:0 hold minimum below limit; 7 idle, read clears.
// - Writing one to control bit 3 wipes CRC error count; bit self-clears.
// - Writing one to control bit 5 wipes self-test error count; bit self-clears.
// - CRC error count advances only while the return link is present.
module lssr_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,

    // Wishbone slave
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic [31:0] dat_o,
    output logic ack_o,

    // Pin levels and return-link status
    input wire logic [lssr_pkg::PIN_COUNT-1:0] pin_level_bits_i,
    input wire logic return_link_present_i,
    input wire logic crc_error_i,
    input wire logic selftest_active_i,

    // Monitored quantities
    input wire lssr_pkg::lssr_sense_t temp_sense_i,
    input wire lssr_pkg::lssr_sense_t pin0_sense_i,
    input wire lssr_pkg::lssr_sense_t pin1_sense_i,

    // Link-detect timer setting
    output logic [lssr_pkg::BC_TIMER_MSB:0] link_det_timer_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Word index of a byte address, or zero when above the decoded window
    function automatic logic [7:0] word_index(input logic [31:0] adr);
        logic [7:0] idx;
        idx = adr[9:2];
        if (adr[31:10] != 22'h000000) begin
            idx = 8'h00;
        end
        return idx;
    endfunction

    // Capture register image: spare bits, peak and trough
    function automatic logic [7:0] capture_image(
        input logic spare_hi,
        input logic spare_lo,
        input lssr_pkg::lssr_alarm_t al
    );
        logic [7:0] img;
        img = lssr_pkg::BYTE_ZERO;
        img[lssr_pkg::CAP_SPARE_HI_BIT] = spare_hi;
        img[lssr_pkg::CAP_PEAK_LSB +: lssr_pkg::READING_W] = al.peak;
        img[lssr_pkg::CAP_SPARE_LO_BIT] = spare_lo;
        img[lssr_pkg::READING_W-1:0] = al.trough;
        return img;
    endfunction

    // Alarm flag register image, one bit per condition
    function automatic logic [7:0] flag_image(
        input lssr_pkg::lssr_alarm_t temp,
        input lssr_pkg::lssr_alarm_t pin1,
        input lssr_pkg::lssr_alarm_t pin0
    );
        logic [7:0] img;
        img = lssr_pkg::BYTE_ZERO;
        img[lssr_pkg::FLAG_OVERTEMP_BIT] = temp.over_flag;
        img[lssr_pkg::FLAG_UNDERTEMP_BIT] = temp.under_flag;
        img[lssr_pkg::FLAG_PIN1_OVER_BIT] = pin1.over_flag;
        img[lssr_pkg::FLAG_PIN1_UNDER_BIT] = pin1.under_flag;
        img[lssr_pkg::FLAG_PIN0_OVER_BIT] = pin0.over_flag;
        img[lssr_pkg::FLAG_PIN0_UNDER_BIT] = pin0.under_flag;
        return img;
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [7:0] idx;
    logic take;
    logic rd_take;
    logic wr_take;
    logic hit_ctrl;
    logic hit_flags;
    logic hit_pin0;
    logic hit_pin1;
    logic hit_temp;

    assign idx = word_index(adr_i);

    // Decoded once and shared by writes, read-clears and spare bits
    assign hit_ctrl = idx == lssr_pkg::IDX_BC_CONTROL;
    assign hit_flags = idx == lssr_pkg::IDX_ALARM_FLAGS;
    assign hit_pin0 = idx == lssr_pkg::IDX_PIN0_CAPTURE;
    assign hit_pin1 = idx == lssr_pkg::IDX_PIN1_CAPTURE;
    assign hit_temp = idx == lssr_pkg::IDX_TEMP_CAPTURE;

    // A request is taken once; ack_o blocks a second take of the same cycle
    assign take = ce_i & cyc_i & stb_i & ~ack_o;
    assign rd_take = take & ~we_i;
    // Only byte lane 0 carries data; a write without it is acknowledged and dropped
    assign wr_take = take & we_i & sel_i[0];

    // ----------------------------------------
    // Back-channel control register
    // ----------------------------------------
    logic crc_wipe_r;
    logic selftest_wipe_r;
    logic bc_spare_r;
    logic bc_write;

    assign bc_write = wr_take & hit_ctrl;

    // Wipe bits act for one cycle and then read back as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_wipe_r <= 1'b0;
            selftest_wipe_r <= 1'b0;
        end else if (ce_i) begin
            crc_wipe_r <= bc_write & dat_i[lssr_pkg::BC_CRC_WIPE_BIT];
            selftest_wipe_r <= bc_write & dat_i[lssr_pkg::BC_SELFTEST_WIPE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bc_spare_r <= 1'b0;
            link_det_timer_o <= lssr_pkg::TIMER_RESET;
        end else if (ce_i && bc_write) begin
            bc_spare_r <= dat_i[lssr_pkg::BC_SPARE_BIT];
            link_det_timer_o <= dat_i[lssr_pkg::BC_TIMER_MSB:0];
        end
    end

    // ----------------------------------------
    // Error counters
    // ----------------------------------------
    logic [lssr_pkg::SELFTEST_CNT_W-1:0] selftest_errs;
    logic [lssr_pkg::CRC_CNT_W-1:0] crc_errs;
    logic selftest_inc;
    logic crc_inc;

    // Self test counting ignores link presence, so a test can run before the link is up
    assign selftest_inc = crc_error_i & selftest_active_i;
    assign crc_inc = crc_error_i & return_link_present_i;

    lssr_err_counter #(
        .WIDTH(lssr_pkg::SELFTEST_CNT_W)
    ) u_selftest_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .inc_i(selftest_inc),
        .wipe_i(selftest_wipe_r),
        .count_o(selftest_errs)
    );

    lssr_err_counter #(
        .WIDTH(lssr_pkg::CRC_CNT_W)
    ) u_crc_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .inc_i(crc_inc),
        .wipe_i(crc_wipe_r),
        .count_o(crc_errs)
    );

    // ----------------------------------------
    // Read-clear strobes
    // ----------------------------------------
    logic flags_clr;
    logic pin0_cap_clr;
    logic pin1_cap_clr;
    logic temp_cap_clr;

    // Clears act at the edge that snapshots the read data
    assign flags_clr = rd_take & hit_flags;
    assign pin0_cap_clr = rd_take & hit_pin0;
    assign pin1_cap_clr = rd_take & hit_pin1;
    assign temp_cap_clr = rd_take & hit_temp;

    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    lssr_pkg::lssr_alarm_t temp_alarm;
    lssr_pkg::lssr_alarm_t pin0_alarm;
    lssr_pkg::lssr_alarm_t pin1_alarm;

    // All three share one flag-register clear, but each keeps its own extremes
    lssr_monitor u_temp_mon (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sense_i(temp_sense_i),
        .flag_clr_i(flags_clr),
        .cap_clr_i(temp_cap_clr),
        .alarm_o(temp_alarm)
    );

    lssr_monitor u_pin0_mon (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sense_i(pin0_sense_i),
        .flag_clr_i(flags_clr),
        .cap_clr_i(pin0_cap_clr),
        .alarm_o(pin0_alarm)
    );

    lssr_monitor u_pin1_mon (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sense_i(pin1_sense_i),
        .flag_clr_i(flags_clr),
        .cap_clr_i(pin1_cap_clr),
        .alarm_o(pin1_alarm)
    );

    // ----------------------------------------
    // Spare read/write bits of the capture registers
    // ----------------------------------------
    logic [1:0] pin0_spare_r;
    logic [1:0] pin1_spare_r;
    logic [1:0] temp_spare_r;
    logic [1:0] spare_wdata;

    assign spare_wdata = {dat_i[lssr_pkg::CAP_SPARE_HI_BIT], dat_i[lssr_pkg::CAP_SPARE_LO_BIT]};

    // Capture fields themselves ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin0_spare_r <= 2'h0;
            pin1_spare_r <= 2'h0;
            temp_spare_r <= 2'h0;
        end else if (ce_i && wr_take) begin
            if (hit_pin0) begin
                pin0_spare_r <= spare_wdata;
            end
            if (hit_pin1) begin
                pin1_spare_r <= spare_wdata;
            end
            if (hit_temp) begin
                temp_spare_r <= spare_wdata;
            end
        end
    end

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = lssr_pkg::BYTE_ZERO;
        case (idx)
            lssr_pkg::IDX_BC_CONTROL: begin
                rd_byte[lssr_pkg::BC_SPARE_BIT] = bc_spare_r;
                rd_byte[lssr_pkg::BC_TIMER_MSB:0] = link_det_timer_o;
            end
            lssr_pkg::IDX_PIN_LEVELS: begin
                rd_byte[lssr_pkg::PIN_COUNT-1:0] = pin_level_bits_i;
            end
            lssr_pkg::IDX_SELFTEST_ERRS: begin
                rd_byte = selftest_errs;
            end
            lssr_pkg::IDX_CRC_ERRS_LOW: begin
                rd_byte = crc_errs[7:0];
            end
            lssr_pkg::IDX_CRC_ERRS_HIGH: begin
                rd_byte = crc_errs[15:8];
            end
            lssr_pkg::IDX_ALARM_FLAGS: begin
                rd_byte = flag_image(temp_alarm, pin1_alarm, pin0_alarm);
            end
            lssr_pkg::IDX_PIN0_CAPTURE: begin
                rd_byte = capture_image(pin0_spare_r[1], pin0_spare_r[0], pin0_alarm);
            end
            lssr_pkg::IDX_PIN1_CAPTURE: begin
                rd_byte = capture_image(pin1_spare_r[1], pin1_spare_r[0], pin1_alarm);
            end
            lssr_pkg::IDX_TEMP_CAPTURE: begin
                rd_byte = capture_image(temp_spare_r[1], temp_spare_r[0], temp_alarm);
            end
            default: begin
                rd_byte = lssr_pkg::BYTE_ZERO;
            end
        endcase
    end

    // ----------------------------------------
    // Acknowledge and read data
    // ----------------------------------------
    // Unmapped addresses still answer, reading zero, so a master never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= take;
        end
    end

    // Data is the image seen at the taking edge, before its own read-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= lssr_pkg::WORD_ZERO;
        end else if (ce_i) begin
            if (rd_take) begin
                dat_o <= {24'h000000, rd_byte};
            end else if (take) begin
                dat_o <= lssr_pkg::WORD_ZERO;
            end
        end
    end

endmodule

/* File: tb/lssr_top_properties.sv */
// Concurrent checks for the link and sensor status register bank.
// Assumes it is bound to lssr_top and sees only that module's ports.
module lssr_top_properties (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Status inputs
    input wire logic [lssr_pkg::PIN_COUNT-1:0] pin_level_bits_i,
    input wire logic return_link_present_i,
    input wire logic crc_error_i,
    input wire logic selftest_active_i,
    input wire lssr_pkg::lssr_sense_t temp_sense_i,
    input wire lssr_pkg::lssr_sense_t pin0_sense_i,
    input wire lssr_pkg::lssr_sense_t pin1_sense_i,
    input wire logic [lssr_pkg::BC_TIMER_MSB:0] link_det_timer_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Reference state
    // ----
    logic req, hit, rd, st_inc, crc_inc, st_wipe_r, crc_wipe_r;
    logic [7:0] idx;
    logic [7:0] st_m;
    logic [15:0] crc_m;
    logic [5:0] flg_m, cond;
    assign req = ce_i & cyc_i & stb_i & ~ack_o;
    assign idx = adr_i[9:2];
    assign hit = req & (adr_i[31:10] == 22'h000000);
    assign rd = hit & ~we_i;
    assign st_inc = crc_error_i & selftest_active_i;
    assign crc_inc = crc_error_i & return_link_present_i;
    assign cond = {temp_sense_i.reading > temp_sense_i.upper_limit, temp_sense_i.reading < temp_sense_i.lower_limit,
        pin1_sense_i.reading > pin1_sense_i.upper_limit, pin1_sense_i.reading < pin1_sense_i.lower_limit,
        pin0_sense_i.reading > pin0_sense_i.upper_limit, pin0_sense_i.reading < pin0_sense_i.lower_limit};
    // Wipe requests act one edge after the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_wipe_r <= 1'b0;
            crc_wipe_r <= 1'b0;
        end else if (ce_i) begin
            st_wipe_r <= hit & we_i & sel_i[0] & (idx == lssr_pkg::IDX_BC_CONTROL) & dat_i[5];
            crc_wipe_r <= hit & we_i & sel_i[0] & (idx == lssr_pkg::IDX_BC_CONTROL) & dat_i[3];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) st_m <= 8'h00;
        else if (ce_i && st_wipe_r) st_m <= {7'h00, st_inc};
        else if (ce_i && st_inc && st_m != 8'hFF) st_m <= st_m + 8'h01;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) crc_m <= 16'h0000;
        else if (ce_i && crc_wipe_r) crc_m <= {15'h0000, crc_inc};
        else if (ce_i && crc_inc && crc_m != 16'hFFFF) crc_m <= crc_m + 16'h0001;
    end
    // A read clears, but a live condition sets again in the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) flg_m <= 6'h00;
        else if (ce_i) flg_m <= ((rd && idx == lssr_pkg::IDX_ALARM_FLAGS) ? 6'h00 : flg_m) | cond;
    end

    // ----
    // Properties
    // ----
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);
    chk_ack_pulse: assert property (
        req |=> ack_o ##1 !ack_o) else $error("ack is not one pulse after a request");
    chk_upper_zero: assert property (
        ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper read data not zero");
    chk_pin_read: assert property (
        rd && idx == lssr_pkg::IDX_PIN_LEVELS |=> dat_o == {28'h0000000, $past(pin_level_bits_i)})
        else $error("pin levels read wrong");
    chk_selftest_count: assert property (
        rd && idx == lssr_pkg::IDX_SELFTEST_ERRS |=> dat_o[7:0] == $past(st_m)) else $error("self test count wrong");
    chk_crc_low_byte: assert property (
        rd && idx == lssr_pkg::IDX_CRC_ERRS_LOW |=> dat_o[7:0] == $past(crc_m[7:0])) else $error("crc low byte wrong");
    chk_crc_high_byte: assert property (
        rd && idx == lssr_pkg::IDX_CRC_ERRS_HIGH |=> dat_o[7:0] == $past(crc_m[15:8])) else $error("crc high byte wrong");
    chk_alarm_flags: assert property (
        rd && idx == lssr_pkg::IDX_ALARM_FLAGS |=> dat_o[7:0] == {2'h0, $past(flg_m)}) else $error("alarm flags wrong");
    chk_wipe_selfclear: assert property (
        rd && idx == lssr_pkg::IDX_BC_CONTROL |=> !dat_o[5] && !dat_o[3]) else $error("wipe bits read back set");
endmodule

bind lssr_top lssr_top_properties u_lssr_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_level_bits_i(pin_level_bits_i), .return_link_present_i(return_link_present_i),
    .crc_error_i(crc_error_i), .selftest_active_i(selftest_active_i), .temp_sense_i(temp_sense_i),
    .pin0_sense_i(pin0_sense_i), .pin1_sense_i(pin1_sense_i), .link_det_timer_o(link_det_timer_o));

/* File: tb/lssr_top_tb.sv */
// Self-checking bench for the link and sensor status register bank.
// Assumes lssr_top answers each Wishbone request one cycle after taking it.
module lssr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ----
    // Signals
    // ----
    localparam logic [8:0] NORM = 9'h0F8;
    logic clk_i, rst_i, ce_i, we_i, cyc_i, stb_i, ack_o, link, crc_err, selftest;
    logic [31:0] adr_i, dat_i, dat_o, xs_state;
    logic [3:0] sel_i, pins;
    logic [2:0] timer;
    lssr_pkg::lssr_sense_t sns [3];
    logic [7:0] exp_q [$];
    int errors, comparisons;

    lssr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .pin_level_bits_i(pins),
        .return_link_present_i(link), .crc_error_i(crc_err), .selftest_active_i(selftest),
        .temp_sense_i(sns[0]), .pin1_sense_i(sns[1]), .pin0_sense_i(sns[2]), .link_det_timer_o(timer));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xs();
        xs_state ^= xs_state << 13;
        xs_state ^= xs_state >> 17;
        xs_state ^= xs_state << 5;
        return xs_state;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Holds the request until ack is sampled; only the watchdog ends a wait on a dead slave
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [7:0] e);
        exp_q.push_back(e);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        sel_i <= s;
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hF, e);
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF, 8'h00);
    endtask
    task automatic pulse(input int n);
        crc_err <= 1'b1;
        repeat (n) @(posedge clk_i);
        crc_err <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic put(input int m, input logic [2:0] r, u, l);
        sns[m] <= {r, u, l};
        repeat (2) @(posedge clk_i);
    endtask
    // Flags then capture, then both again to see them back at idle
    task automatic pair(input int m, input logic [7:0] f, input logic [7:0] c);
        rd(32'h15C, f);
        rd(32'h168 - 4 * m, c);
        rd(32'h15C, 8'h00);
        rd(32'h168 - 4 * m, 8'h07);
    endtask

    // ----
    // Clock, watchdog, read-data monitor
    // ----
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        check("watchdog", 32'h1, 32'h0);
        report_and_stop();
    end
    always @(posedge clk_i) begin
        if (ack_o === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected ack", 32'h1, 32'h0);
            else check("dat_o", dat_o, {24'h000000, exp_q.pop_front()});
        end
    end

    // ----
    // Scenarios
    // ----
    initial begin
        logic [31:0] p;
        rst_i = 1'b1;
        ce_i = 1'b1;
        {we_i, cyc_i, stb_i, link, crc_err, selftest} = 6'h00;
        adr_i = 32'h0;
        dat_i = 32'h0;
        sel_i = 4'h0;
        pins = 4'h0;
        for (int i = 0; i < 3; i++) sns[i] = NORM;
        xs_state = 32'h00000002;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) rd(32'h14C + 4 * i, (i > 4) ? 8'h07 : 8'h00);
        rd(32'h400, 8'h00);
        rd(32'h180, 8'h00);
        bus(1'b1, 32'h124, 8'h07, 4'hE, 8'h00);
        rd(32'h124, 8'h00);
        for (int i = 0; i < 4; i++) begin
            p = xs();
            pins <= p[3:0];
            @(posedge clk_i);
            rd(32'h14C, {4'h0, p[3:0]});
        end
        selftest <= 1'b1;
        pulse(5);
        selftest <= 1'b0;
        link <= 1'b1;
        pulse(300);
        wr(32'h150, 8'hAA);
        rd(32'h150, 8'h05);
        rd(32'h154, 8'h2C);
        rd(32'h158, 8'h01);
        wr(32'h124, 8'h08);
        rd(32'h154, 8'h00);
        rd(32'h158, 8'h00);
        rd(32'h150, 8'h05);
        wr(32'h124, 8'h27);
        rd(32'h150, 8'h00);
        rd(32'h124, 8'h07);
        check("link_det_timer_o", {29'h0, timer}, 32'h7);
        selftest <= 1'b1;
        link <= 1'b0;
        pulse(300);
        rd(32'h150, 8'hFF);
        rd(32'h154, 8'h00);
        ce_i <= 1'b0;
        link <= 1'b1;
        pulse(4);
        ce_i <= 1'b1;
        link <= 1'b0;
        rd(32'h154, 8'h00);
        put(0, 3'h3, 3'h3, 3'h3);
        pair(0, 8'h00, 8'h07);
        for (int m = 0; m < 3; m++) begin
            put(m, 3'h5, 3'h3, 3'h0);
            put(m, 3'h6, 3'h3, 3'h0);
            put(m, 3'h4, 3'h3, 3'h0);
            put(m, 3'h3, 3'h7, 3'h0);
            pair(m, 8'h20 >> (2 * m), 8'h67);
            put(m, 3'h2, 3'h7, 3'h4);
            put(m, 3'h1, 3'h7, 3'h4);
            put(m, 3'h3, 3'h7, 3'h4);
            put(m, 3'h3, 3'h7, 3'h0);
            pair(m, 8'h10 >> (2 * m), 8'h01);
        end
        put(0, 3'h6, 3'h3, 3'h0);
        rd(32'h15C, 8'h20);
        rd(32'h15C, 8'h20);
        rd(32'h168, 8'h67);
        rd(32'h168, 8'h67);
        put(0, 3'h3, 3'h7, 3'h0);
        pair(0, 8'h20, 8'h67);
        wr(32'h160, 8'hFF);
        rd(32'h160, 8'h8F);
        report_and_stop();
    end
endmodule
